//--- common/tcr_pkg.sv
package tcr_pkg;
  // Device select: bits 0..3 fixed, bits 4..5 strapped
  localparam logic [3:0] DEV_FIXED      = 4'hD;
  // Instruction selects on bits 6..8
  localparam logic [2:0] OP_LOAD_DATA   = 3'h0;
  localparam logic [2:0] OP_READ_CMD    = 3'h1;
  localparam logic [2:0] OP_READ_DATA   = 3'h2;
  localparam logic [2:0] OP_LOAD_CMD    = 3'h4;
  // Command register field positions
  localparam int         CMD_UNIT_BIT   = 0;
  localparam int         CMD_DIR_BIT    = 1;
  localparam int         CMD_GO_BIT     = 2;
  localparam int         CMD_WRITE_BIT  = 3;
  localparam logic [3:0] CMD_RESET      = 4'h0;
  // Timing
  localparam int         CLK_HZ         = 25000000;
  localparam int         UTS_DELAY_MS   = 120;
  localparam int         UTS_CYCLES     = (CLK_HZ / 1000) * UTS_DELAY_MS;
  localparam int         CNT_W          = 22;

  typedef struct packed {
    logic sel_err;
    logic time_err;
    logic write_lockout;
  } tcr_drive_stat_t;

  typedef struct packed {
    logic xfer_ctl_a;
    logic xfer_ctl_b;
  } tcr_xfer_t;
endpackage : tcr_pkg

//--- rtl/tcr_ctl.sv
`timescale 1ns/100ps
module tcr_ctl
  import tcr_pkg::*;
#(
  parameter int UTS_COUNT = UTS_CYCLES
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_io_pause,
  input  wire logic [11:0]     i_memory_word_bits,
  input  wire logic [1:0]      i_dev_strap,
  input  wire logic [11:0]     i_ac,
  input  wire logic            i_exec_pulse_three,
  input  wire logic            i_exec_pulse_four,
  input  wire logic            i_data_pulse_zero,
  input  wire logic            i_initialize,
  input  wire logic            i_run,
  input  wire logic            i_power_ok,
  input  wire logic            i_format_mode_on,
  input  wire tcr_drive_stat_t i_drive_stat,
  input  wire logic            i_track_pulse,
  output logic                 o_device_match,
  output logic [7:0]           o_instr_sel,
  output tcr_xfer_t            o_xfer,
  output logic [11:0]          o_data_bus,
  output logic                 o_data_bus_en,
  output logic                 o_unit,
  output logic                 o_reverse,
  output logic                 o_go,
  output logic                 o_write_mode,
  output logic                 o_halt_all_drives,
  output logic                 o_word_write_gate,
  output logic                 o_speed_reached,
  output logic                 o_timing_track_gate,
  output logic                 o_change_pending,
  output logic                 o_mark_clear,
  output logic                 o_one_line_clear,
  output logic                 o_four_line_clear
);

  // Control and status pins and memory word bits pass two flops; i_ac and i_dev_strap are used without synchronising.
  localparam int NS = 21;
  logic [NS-1:0] s1_q, s2_q;
  logic [NS-1:0] pin_raw;
  assign pin_raw = {i_io_pause, i_exec_pulse_three, i_exec_pulse_four, i_data_pulse_zero,
                    i_initialize, i_run, i_power_ok, i_format_mode_on, i_drive_stat,
                    i_track_pulse, i_memory_word_bits[11:3]};

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  logic       pause_s, tp3_s, tp4_s, dtp0_s, init_s, run_s, pok_s, fmt_s, trk_s;
  logic       sel_err_s, time_err_s, wlock_s;
  logic [8:0] md_s;
  assign {pause_s, tp3_s, tp4_s, dtp0_s, init_s, run_s, pok_s, fmt_s,
          sel_err_s, time_err_s, wlock_s, trk_s, md_s} = s2_q;

  // Edge detect pulses so a wide pulse acts once
  logic tp3_d1_q, tp4_d1_q, dtp0_d1_q, trk_d1_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tp3_d1_q  <= 1'b0;
      tp4_d1_q  <= 1'b0;
      dtp0_d1_q <= 1'b0;
      trk_d1_q  <= 1'b0;
    end else begin
      tp3_d1_q  <= tp3_s;
      tp4_d1_q  <= tp4_s;
      dtp0_d1_q <= dtp0_s;
      trk_d1_q  <= trk_s;
    end
  end
  logic tp3_rise, tp4_rise, dtp0_rise, trk_rise;
  assign tp3_rise  = tp3_s & ~tp3_d1_q;
  assign tp4_rise  = tp4_s & ~tp4_d1_q;
  assign dtp0_rise = dtp0_s & ~dtp0_d1_q;
  assign trk_rise  = trk_s & ~trk_d1_q;

  function automatic logic [7:0] one_of_eight(input logic [2:0] code);
    one_of_eight = 8'h01 << code;
  endfunction : one_of_eight

  // md_s[8:0] holds bits 0..8; bit 0 is md_s[8] (bit 0 is MSB)
  logic       match;
  logic [2:0] op;
  logic [7:0] sel;
  assign op    = {md_s[2], md_s[1], md_s[0]};
  assign match = pause_s && (md_s[8:5] == DEV_FIXED) && (md_s[4:3] == i_dev_strap);
  assign sel   = match ? one_of_eight(op) : 8'h00;

  logic ld_cmd, ld_data, rd_cmd, rd_data;
  assign ld_cmd  = sel[OP_LOAD_CMD];
  assign ld_data = sel[OP_LOAD_DATA];
  assign rd_cmd  = sel[OP_READ_CMD];
  assign rd_data = sel[OP_READ_DATA];

  always_comb begin
    o_xfer = '{xfer_ctl_a: 1'b1, xfer_ctl_b: 1'b1};
    if (ld_cmd) begin
      o_xfer = '{xfer_ctl_a: 1'b0, xfer_ctl_b: 1'b1};
    end else if (rd_cmd || rd_data) begin
      o_xfer = '{xfer_ctl_a: 1'b0, xfer_ctl_b: 1'b0};
    end
  end
  assign o_device_match = match;
  assign o_instr_sel    = sel;

  logic clear_all;
  assign clear_all = init_s;

  // Command register
  logic [3:0] cmd_q;
  logic       ld_exec;
  logic       cmd_change;
  logic       wr_kill;
  assign ld_exec    = ld_cmd && tp3_rise;
  assign cmd_change = ld_exec && (cmd_q[2:0] != i_ac[2:0]);
  assign wr_kill    = sel_err_s | time_err_s | wlock_s | ~pok_s | ~run_s;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_q <= CMD_RESET;
    end else if (clear_all) begin
      cmd_q <= CMD_RESET;
    end else begin
      if (ld_exec) begin
        cmd_q[CMD_UNIT_BIT]  <= i_ac[0];
        cmd_q[CMD_DIR_BIT]   <= i_ac[1];
        cmd_q[CMD_GO_BIT]    <= i_ac[2];
        cmd_q[CMD_WRITE_BIT] <= i_ac[3];
      end
      if (!run_s) begin
        cmd_q[CMD_GO_BIT] <= 1'b0;
      end
      if (wr_kill) begin
        cmd_q[CMD_WRITE_BIT] <= 1'b0;
      end
    end
  end

  // Go latched on pulse four so unit select settles first
  logic go_lat_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      go_lat_q <= 1'b0;
    end else if (clear_all || !run_s) begin
      go_lat_q <= 1'b0;
    end else if (tp4_rise) begin
      go_lat_q <= cmd_q[CMD_GO_BIT];
    end
  end

  // Change pending and up-to-speed delay
  logic                chg_q;
  logic                spd_q;
  logic [CNT_W-1:0]    cnt_q;
  logic                timing_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chg_q <= 1'b0;
    end else if (clear_all) begin
      chg_q <= 1'b0;
    end else if (cmd_change) begin
      chg_q <= 1'b1;
    end else if (tp4_rise && chg_q) begin
      chg_q <= 1'b0;
    end
  end

  // Counter restarts on every change, so timeout runs from the last load that changed bits 0..2
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q    <= '0;
      timing_q <= 1'b0;
    end else if (clear_all) begin
      cnt_q    <= '0;
      timing_q <= 1'b0;
    end else if (chg_q) begin
      cnt_q    <= '0;
      timing_q <= 1'b1;
    end else if (timing_q) begin
      if (cnt_q == CNT_W'(UTS_COUNT - 1)) begin
        timing_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      spd_q <= 1'b0;
    end else if (clear_all || cmd_change || chg_q || !run_s || !cmd_q[CMD_GO_BIT]) begin
      spd_q <= 1'b0;
    end else if (timing_q && cnt_q == CNT_W'(UTS_COUNT - 1)) begin
      spd_q <= cmd_q[CMD_GO_BIT];
    end
  end

  // Track gate opens on first track pulse after speed reached
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timing_track_gate <= 1'b0;
    end else if (!spd_q) begin
      o_timing_track_gate <= 1'b0;
    end else if (trk_rise) begin
      o_timing_track_gate <= 1'b1;
    end
  end

  // Write latch: set at data pulse zero while write mode held
  logic wr_lat_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_lat_q <= 1'b0;
    end else if (!cmd_q[CMD_WRITE_BIT]) begin
      wr_lat_q <= 1'b0;
    end else if (dtp0_rise) begin
      wr_lat_q <= 1'b1;
    end
  end

  // Read-command returns the register; load-command leaves the bus disabled
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data_bus    <= '0;
      o_data_bus_en <= 1'b0;
    end else begin
      o_data_bus_en <= rd_cmd;
      o_data_bus    <= rd_cmd ? {8'h00, cmd_q} : 12'h000;
    end
  end

  assign o_unit            = cmd_q[CMD_UNIT_BIT];
  assign o_reverse         = cmd_q[CMD_DIR_BIT];
  assign o_write_mode      = cmd_q[CMD_WRITE_BIT];
  assign o_go              = go_lat_q & pok_s & run_s;
  assign o_halt_all_drives = ~run_s;
  assign o_word_write_gate = wr_lat_q & ~fmt_s & pok_s & spd_q;
  assign o_speed_reached   = spd_q;
  assign o_change_pending  = chg_q;
  assign o_mark_clear      = chg_q & tp4_rise;
  assign o_one_line_clear  = ~spd_q | clear_all | (tp3_rise & (ld_data | rd_cmd | rd_data));
  assign o_four_line_clear = o_one_line_clear;

  a_go_needs_power: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_go |-> pok_s && run_s) else $error("go without power or run");
  a_run_loss_go: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !run_s |=> !cmd_q[CMD_GO_BIT]) else $error("go kept after run loss");
  a_wr_kill: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    wr_kill |=> !o_write_mode) else $error("write not cleared");
  a_ld_cmd_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ld_exec && !clear_all && run_s && !wr_kill |=> cmd_q == $past(i_ac[3:0]))
    else $error("command load wrong");
  a_change_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    cmd_change |=> !spd_q ##1 !spd_q) else $error("speed not cleared");
  a_speed_go: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    spd_q |-> cmd_q[CMD_GO_BIT]) else $error("speed without go");
  a_wgate_speed: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_word_write_gate |-> spd_q && !fmt_s) else $error("write gate early");
  a_track_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $fell(spd_q) |=> !o_timing_track_gate) else $error("track gate kept");
  a_xfer_load: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ld_cmd |-> !o_xfer.xfer_ctl_a && o_xfer.xfer_ctl_b) else $error("xfer lines wrong");
  a_mark_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    chg_q && tp4_rise |-> o_mark_clear)
    else $error("mark clear missing");
  a_line_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !spd_q |-> o_one_line_clear && o_four_line_clear)
    else $error("line flags not cleared");
  a_go_lat_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !tp4_rise && !clear_all && run_s |=> $stable(go_lat_q))
    else $error("go latch moved early");
  a_go_lat_load: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    tp4_rise && !clear_all && run_s |=> go_lat_q == $past(cmd_q[CMD_GO_BIT]))
    else $error("go latch not loaded");
  a_init_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    clear_all |=> cmd_q == CMD_RESET && !chg_q && !spd_q)
    else $error("initialize left state");
  a_pend_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    chg_q && tp4_rise && !cmd_change && !clear_all |=> !chg_q)
    else $error("pending not cleared");
  a_pend_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    cmd_change && !clear_all |=> chg_q)
    else $error("pending not set");
  a_halt_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !run_s |-> o_halt_all_drives)
    else $error("halt missing");
  a_rd_cmd_bus: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    rd_cmd |=> o_data_bus_en && o_data_bus == {8'h00, $past(cmd_q)})
    else $error("read command data wrong");
  a_rd_cmd_keep: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    rd_cmd && !clear_all && run_s && !wr_kill |=> $stable(cmd_q))
    else $error("read command disturbed register");
  a_wlat_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    dtp0_rise && cmd_q[CMD_WRITE_BIT] |=> wr_lat_q)
    else $error("write latch not set");
  a_wlat_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !cmd_q[CMD_WRITE_BIT] |=> !wr_lat_q)
    else $error("write latch kept");
  a_spd_timeout: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    timing_q && cnt_q == CNT_W'(UTS_COUNT - 1) && cmd_q[CMD_GO_BIT] && !clear_all
    && !cmd_change && !chg_q && run_s |=> spd_q) else $error("speed not reached");
  a_dev_match: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_device_match |-> pause_s)
    else $error("match outside pause");
  a_instr_onehot: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    match |-> $onehot(o_instr_sel))
    else $error("instruction select not one-hot");

endmodule : tcr_ctl

//--- verification/tcr_drive_model.sv
`timescale 1ns/100ps
module tcr_drive_model
  import tcr_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic       i_lock_req,
  output tcr_drive_stat_t o_stat,
  output logic            o_track_pulse
);
  logic [3:0] ph_q;
  // Time track only turns while the transport is commanded to move
  always_ff @(posedge i_core_clk) begin
    ph_q <= i_go ? ph_q + 4'h1 : 4'h0;
  end
  assign o_track_pulse = i_go & (ph_q == 4'hF);
  // Lockout stands for a reel mounted without its write ring
  assign o_stat = '{sel_err: 1'b0, time_err: 1'b0, write_lockout: i_lock_req};
endmodule : tcr_drive_model

//--- verification/tape_command_register_ctl_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tape_command_register_ctl_test;
  import tcr_pkg::*;
  localparam int N = 20;
  logic clk, rst_b = 0, pause = 0, tp3 = 0, tp4 = 0, dtp0 = 0, init = 0;
  logic run = 1, pok = 1, fmt = 0, lock = 0, trk, mt, match, dbe, unit, rev, go;
  logic wm, halt, wwg, spd, ttg, pend;
  logic [1:0] strap = 2'h1;
  logic [11:0] md = 12'h0, ac = 12'h0, dbus, db;
  logic [7:0] isel, is;
  tcr_drive_stat_t stat;
  tcr_xfer_t xfer, xf;
  int error_cnt = 0, num_checks = 0, cyc = 0;

  tcr_ctl #(.UTS_COUNT(N)) uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_io_pause(pause),
    .i_memory_word_bits(md), .i_dev_strap(strap), .i_ac(ac), .i_exec_pulse_three(tp3),
    .i_exec_pulse_four(tp4), .i_data_pulse_zero(dtp0), .i_initialize(init), .i_run(run),
    .i_power_ok(pok), .i_format_mode_on(fmt), .i_drive_stat(stat), .i_track_pulse(trk),
    .o_device_match(match), .o_instr_sel(isel), .o_xfer(xfer), .o_data_bus(dbus),
    .o_data_bus_en(dbe), .o_unit(unit), .o_reverse(rev), .o_go(go), .o_write_mode(wm),
    .o_halt_all_drives(halt), .o_word_write_gate(wwg), .o_speed_reached(spd),
    .o_timing_track_gate(ttg), .o_change_pending(pend), .o_mark_clear(),
    .o_one_line_clear(), .o_four_line_clear());
  tcr_drive_model drive (.i_core_clk(clk), .i_go(go), .i_lock_req(lock), .o_stat(stat),
    .o_track_pulse(trk));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Pins pass a two-flop synchroniser, so every level is held several cycles
  task automatic instr(input logic [1:0] sel, input logic [2:0] op, input logic [3:0] a);
    md = {DEV_FIXED, sel, op, 3'h0};
    ac = {8'h0, a};
    pause = 1;
    repeat (4) @(negedge clk);
    xf = xfer;
    db = dbus;
    mt = match;
    is = isel;
    tp3 = 1;
    repeat (2) @(negedge clk);
    tp3 = 0;
    repeat (3) @(negedge clk);
    tp4 = 1;
    repeat (2) @(negedge clk);
    tp4 = 0;
    repeat (4) @(negedge clk);
    pause = 0;
    repeat (3) @(negedge clk);
  endtask : instr

  task automatic wait_spd;
    int k;
    k = 0;
    while (spd !== 1'b1 && k < 3 * N) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_spd

  task automatic t_load;
    `CHK("unit", 1'b0, unit)
    `CHK("halt", 1'b0, halt)
    instr(strap, OP_LOAD_CMD, 4'hB);
    `CHK("xfer", 2'b01, xf)
    `CHK("isel", 8'h10, is)
    `CHK("unit", 1'b1, unit)
    `CHK("rev", 1'b1, rev)
    `CHK("wm", 1'b1, wm)
    `CHK("go", 1'b0, go)
    instr(strap, OP_READ_CMD, 4'h0);
    `CHK("xfer", 2'b00, xf)
    `CHK("dbus", 12'h00B, db)
    `CHK("wm", 1'b1, wm)
    instr(strap, OP_LOAD_DATA, 4'h0);
    `CHK("xfer", 2'b11, xf)
    instr(2'h2, OP_LOAD_CMD, 4'h0);
    `CHK("match", 1'b0, mt)
    `CHK("unit", 1'b1, unit)
    $display("test load done");
  endtask : t_load

  task automatic t_speed;
    instr(strap, OP_LOAD_CMD, 4'h4);
    `CHK("go", 1'b1, go)
    `CHK("pend", 1'b0, pend)
    `CHK("spd", 1'b0, spd)
    wait_spd();
    `CHK("spd", 1'b1, spd)
    instr(strap, OP_LOAD_CMD, 4'hC);
    `CHK("spd", 1'b1, spd)
    dtp0 = 1;
    repeat (4) @(negedge clk);
    dtp0 = 0;
    `CHK("wwg", 1'b1, wwg)
    instr(strap, OP_LOAD_CMD, 4'hE);
    `CHK("spd", 1'b0, spd)
    `CHK("ttg", 1'b0, ttg)
    `CHK("wwg", 1'b0, wwg)
    wait_spd();
    `CHK("spd", 1'b1, spd)
    $display("test speed done");
  endtask : t_speed

  task automatic t_fault;
    lock = 1;
    repeat (4) @(negedge clk);
    lock = 0;
    `CHK("wm", 1'b0, wm)
    pok = 0;
    repeat (4) @(negedge clk);
    `CHK("go", 1'b0, go)
    pok = 1;
    run = 0;
    repeat (4) @(negedge clk);
    `CHK("halt", 1'b1, halt)
    run = 1;
    repeat (4) @(negedge clk);
    `CHK("go", 1'b0, go)
    instr(strap, OP_LOAD_CMD, 4'hF);
    init = 1;
    repeat (4) @(negedge clk);
    init = 0;
    repeat (4) @(negedge clk);
    `CHK("unit", 1'b0, unit)
    `CHK("spd", 1'b0, spd)
    $display("test fault done");
  endtask : t_fault

  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    t_load();
    t_speed();
    t_fault();
    test_done();
  end
endmodule : tape_command_register_ctl_test
